// File: test_two_wire_irq_mask_and_data_regs.sv
// Self-checking bench for the two-wire controller register bank
`timescale 1ns/1ps

module test_two_wire_irq_mask_and_data_regs;

    // ****************************************
    // Signals and design instance
    // ****************************************
    logic                         clk = 1'b0;
    logic                         srst = 1'b1;
    logic [twr_pkg::ADDR_W-1:0]   paddr = '0;
    logic                         psel = 1'b0;
    logic                         penable = 1'b0;
    logic                         pwrite = 1'b0;
    logic [31:0]                  pwdata = '0;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic                         rxByteValid = 1'b0;
    logic [7:0]                   rxByte = '0;
    logic                         txByteTaken = 1'b0;
    logic [31:0]                  eventPulse = '0;
    logic [7:0]                   txByte;
    logic                         txReady;
    logic                         rxReady;
    logic                         irq;
    int                           bad_count = 0;
    int                           compares = 0;
    int                           cycles = 0;

    twr_regs dut (
        .clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxByteValid(rxByteValid), .rxByte(rxByte),
        .txByteTaken(txByteTaken), .eventPulse(eventPulse),
        .txByte(txByte), .txReady(txReady), .rxReady(rxReady), .irq(irq)
    );

    always #12.5 clk = ~clk;

    `define CHK(got, exp) begin \
        compares++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", \
                     $time, (got), (exp)); \
        end \
    end

    // ****************************************
    // Bus and engine tasks
    // ****************************************
    task automatic tally_and_finish();
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, '0, r, e);
        `CHK(r, x)
        `CHK(e, xe)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        `CHK(e, xe)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic evt(input logic [31:0] ev, input logic rv,
                       input logic [7:0] rb, input logic tk);
        @(posedge clk);
        eventPulse <= ev;
        rxByteValid <= rv;
        rxByte <= rb;
        txByteTaken <= tk;
        @(posedge clk);
        eventPulse <= '0;
        rxByteValid <= 1'b0;
        txByteTaken <= 1'b0;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        settle(1);
        `CHK(irq, 1'b0)
        `CHK(txReady, 1'b1)
        rd(twr_pkg::OFS_IRQ_MASK, twr_pkg::MASK_RST, 1'b0);
        rd(twr_pkg::OFS_RX_HOLD, 32'h00000000, 1'b0);
        rd(twr_pkg::OFS_TX_HOLD, 32'h00000000, 1'b0);
        rd(twr_pkg::OFS_STATUS, twr_pkg::STATUS_RST, 1'b0);
        // Set and clear with partial patterns; zeros must leave bits alone
        wr(twr_pkg::OFS_IRQ_SET, 32'h00000011, 1'b0);
        wr(twr_pkg::OFS_IRQ_SET, 32'h00000100, 1'b0);
        rd(twr_pkg::OFS_IRQ_MASK, 32'h00000111, 1'b0);
        wr(twr_pkg::OFS_IRQ_SET, 32'hffffffff, 1'b0);
        rd(twr_pkg::OFS_IRQ_MASK, 32'h0000ff77, 1'b0);
        wr(twr_pkg::OFS_IRQ_MASK, 32'h00000000, 1'b1);
        rd(twr_pkg::OFS_IRQ_SET, 32'h00000000, 1'b0);
        wr(twr_pkg::OFS_IRQ_CLR, 32'h00000011, 1'b0);
        rd(twr_pkg::OFS_IRQ_MASK, 32'h0000ff66, 1'b0);
        wr(twr_pkg::OFS_IRQ_CLR, 32'hffffffff, 1'b0);
        rd(twr_pkg::OFS_IRQ_MASK, 32'h00000000, 1'b0);
        rd(8'h00, 32'h00000000, 1'b1);
        // Each pulsed source: masked, then unmasked, then cleared
        for (int i = 0; i < 16; i++) begin
            if (twr_pkg::EVT_MASK[i]) begin
                evt(32'h1 << i, 1'b0, 8'h00, 1'b0);
                settle(2);
                `CHK(irq, 1'b0)
                rd(twr_pkg::OFS_STATUS, 32'h4 | (32'h1 << i), 1'b0);
                wr(twr_pkg::OFS_IRQ_SET, 32'h1 << i, 1'b0);
                settle(2);
                `CHK(irq, 1'b1)
                wr(twr_pkg::OFS_STATUS, 32'h1 << i, 1'b0);
                settle(2);
                `CHK(irq, 1'b0)
                wr(twr_pkg::OFS_IRQ_CLR, 32'h1 << i, 1'b0);
            end
        end
        // Receive path, then two bytes back to back for overrun
        evt('0, 1'b1, 8'ha5, 1'b0);
        settle(1);
        `CHK(rxReady, 1'b1)
        wr(twr_pkg::OFS_IRQ_SET, 32'h00000002, 1'b0);
        settle(2);
        `CHK(irq, 1'b1)
        wr(twr_pkg::OFS_RX_HOLD, 32'h000000ff, 1'b1);
        rd(twr_pkg::OFS_RX_HOLD, 32'h000000a5, 1'b0);
        settle(2);
        `CHK(rxReady, 1'b0)
        `CHK(irq, 1'b0)
        evt('0, 1'b1, 8'h3c, 1'b0);
        evt('0, 1'b1, 8'h5a, 1'b0);
        rd(twr_pkg::OFS_STATUS, 32'h00000046, 1'b0);
        rd(twr_pkg::OFS_RX_HOLD, 32'h0000005a, 1'b0);
        wr(twr_pkg::OFS_STATUS, 32'h00000040, 1'b0);
        wr(twr_pkg::OFS_IRQ_CLR, 32'h00000002, 1'b0);
        // Transmit path
        wr(twr_pkg::OFS_IRQ_SET, 32'h00000004, 1'b0);
        wr(twr_pkg::OFS_TX_HOLD, 32'hffffffc3, 1'b0);
        settle(2);
        `CHK(txByte, 8'hc3)
        `CHK(txReady, 1'b0)
        `CHK(irq, 1'b0)
        rd(twr_pkg::OFS_TX_HOLD, 32'h000000c3, 1'b0);
        evt('0, 1'b0, 8'h00, 1'b1);
        settle(2);
        `CHK(txReady, 1'b1)
        `CHK(irq, 1'b1)
        // A byte landing in the setup cycle of a read survives that read
        fork
            rd(twr_pkg::OFS_RX_HOLD, 32'h0000005a, 1'b0);
            begin
                @(posedge clk);
                rxByteValid <= 1'b1;
                rxByte <= 8'h77;
                @(posedge clk);
                rxByteValid <= 1'b0;
            end
        join
        settle(1);
        `CHK(rxReady, 1'b1)
        rd(twr_pkg::OFS_RX_HOLD, 32'h00000077, 1'b0);
        settle(1);
        `CHK(rxReady, 1'b0)
        // An event in the cycle of its own clear stays set
        evt(32'h00000001, 1'b0, 8'h00, 1'b0);
        fork
            wr(twr_pkg::OFS_STATUS, 32'h00000001, 1'b0);
            begin
                repeat (2) @(posedge clk);
                eventPulse <= 32'h00000001;
                @(posedge clk);
                eventPulse <= 32'h00000000;
            end
        join
        rd(twr_pkg::OFS_STATUS, 32'h00000005, 1'b0);
        // Reset in mid-run clears the mask and drops the interrupt
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        settle(2);
        `CHK(irq, 1'b0)
        rd(twr_pkg::OFS_IRQ_MASK, 32'h00000000, 1'b0);
        tally_and_finish();
    end

endmodule

// File: twr_pkg.sv
// Constants shared by the two-wire controller register bank
package twr_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFS_STATUS    = 8'h20;
    localparam logic [7:0]  OFS_IRQ_SET   = 8'h24;
    localparam logic [7:0]  OFS_IRQ_CLR   = 8'h28;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h2c;
    localparam logic [7:0]  OFS_RX_HOLD   = 8'h30;
    localparam logic [7:0]  OFS_TX_HOLD   = 8'h34;

    // ****************************************
    // Source bit positions
    // ****************************************
    localparam int BIT_XFER_DONE   = 0;
    localparam int BIT_RX_READY    = 1;
    localparam int BIT_TX_READY    = 2;
    localparam int BIT_SLAVE_ACC   = 4;
    localparam int BIT_GEN_CALL    = 5;
    localparam int BIT_OVERRUN     = 6;
    localparam int BIT_NOT_ACK     = 8;
    localparam int BIT_ARB_LOST    = 9;
    localparam int BIT_CLK_WAIT    = 10;
    localparam int BIT_SLAVE_END   = 11;
    localparam int BIT_RX_BUF_END  = 12;
    localparam int BIT_TX_BUF_END  = 13;
    localparam int BIT_RX_BUF_FULL = 14;
    localparam int BIT_TX_BUF_EMPT = 15;

    // All implemented sources; bits 3, 7 and 16..31 stay zero
    localparam logic [31:0] SRC_MASK  = 32'h0000ff77;
    // Sources that the engine reports as pulses (sticky, write one clears)
    localparam logic [31:0] EVT_MASK  = 32'h0000ff71;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] MASK_RST   = 32'h00000000;
    localparam logic [31:0] STATUS_RST = 32'h00000004;
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [31:0] RDATA_RST  = 32'h00000000;

endpackage

// File: twr_regs.sv
// Register bank of the two-wire controller: mask, status, holding bytes
//
// Notes on behaviour
// [R1] Enable-register write sets mask bits where written one; zeros ignored.
// [R2] Disable-register write clears mask bits written one; zeros ignored.
// [R3] Mask register reads enabled sources as one; read-only, resets to zero.
// [R4] Low sources at bits 0,1,2,4,5,6; bits 3 and 7 unused.
// [R5] Upper sources at bits 8 to 15; bits 16 to 31 unused.
// [R6] Receive holding register shows last byte in bits 7..0, upper zero.
// [R7] Transmit holding register takes next byte in bits 7..0; readable.
// [R8] Receive-ready sets when byte lands, clears on holding register read unless a byte landed in that read's setup cycle.
// [R9] Transmit-ready clears on holding write, sets when byte reaches shifter.
// [R10] Interrupt high while any set status flag has its mask bit one.
`timescale 1ns/1ps

module twr_regs (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      srst,
    // APB slave
    input  wire logic [twr_pkg::ADDR_W-1:0] paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Bus engine side
    input  wire logic                      rxByteValid,
    input  wire logic [7:0]                rxByte,
    input  wire logic                      txByteTaken,
    input  wire logic [31:0]               eventPulse,
    output logic      [7:0]                txByte,
    output logic                           txReady,
    output logic                           rxReady,
    // Interrupt
    output logic                           irq
);

    // ****************************************
    // Bus decode
    // ****************************************
    logic        setupPhase;
    logic        accessWr;
    logic        accessRd;
    logic        hitStatus;
    logic        hitSet;
    logic        hitClr;
    logic        hitMask;
    logic        hitRx;
    logic        hitTx;
    logic        mapped;
    logic        roWrite;

    assign setupPhase = psel && !penable;
    assign accessWr   = psel && penable && pwrite;
    assign accessRd   = psel && penable && !pwrite;
    assign hitStatus  = (paddr == twr_pkg::OFS_STATUS);
    assign hitSet     = (paddr == twr_pkg::OFS_IRQ_SET);
    assign hitClr     = (paddr == twr_pkg::OFS_IRQ_CLR);
    assign hitMask    = (paddr == twr_pkg::OFS_IRQ_MASK);
    assign hitRx      = (paddr == twr_pkg::OFS_RX_HOLD);
    assign hitTx      = (paddr == twr_pkg::OFS_TX_HOLD);
    assign mapped     = hitStatus | hitSet | hitClr | hitMask | hitRx | hitTx;
    // Writes to read-only words are flagged rather than silently dropped
    assign roWrite    = pwrite && (hitMask || hitRx);

    // Zero wait states: read data is staged in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!mapped || roWrite);

    // ****************************************
    // Register state
    // ****************************************
    logic [31:0] maskReg;
    logic [31:0] maskNext;
    logic [31:0] statReg;
    logic [31:0] statNext;
    logic [7:0]  rxReg;
    logic [7:0]  rxNext;
    logic [7:0]  txReg;
    logic [7:0]  txNext;
    logic [31:0] rdataReg;
    logic [31:0] rdataNext;
    logic        staleReg;
    logic        staleNext;
    logic        irqReg;
    logic        irqNext;

    // Mask: set and clear words act only on implemented sources
    always_comb begin
        maskNext = maskReg;
        if (accessWr && hitSet) begin
            maskNext = maskNext | (pwdata & twr_pkg::SRC_MASK); // R1 R4 R5
        end
        if (accessWr && hitClr) begin
            maskNext = maskNext & ~(pwdata & twr_pkg::SRC_MASK); // R2
        end
    end

    // Status: clears first, then sets, so a coinciding event wins
    always_comb begin
        statNext = statReg;
        if (accessWr && hitStatus) begin
            statNext = statNext & ~(pwdata & twr_pkg::EVT_MASK);
        end
        // A byte that landed after the read data was staged is not consumed
        if (accessRd && hitRx && !staleReg) begin
            statNext[twr_pkg::BIT_RX_READY] = 1'b0; // R8
        end
        if (accessWr && hitTx) begin
            statNext[twr_pkg::BIT_TX_READY] = 1'b0; // R9
        end
        statNext = statNext | (eventPulse & twr_pkg::EVT_MASK);
        if (rxByteValid) begin
            statNext[twr_pkg::BIT_RX_READY] = 1'b1; // R8
            if (statReg[twr_pkg::BIT_RX_READY]) begin
                statNext[twr_pkg::BIT_OVERRUN] = 1'b1;
            end
        end
        if (txByteTaken) begin
            statNext[twr_pkg::BIT_TX_READY] = 1'b1; // R9
        end
    end

    // Holding bytes
    always_comb begin
        rxNext = rxReg;
        txNext = txReg;
        if (rxByteValid) begin
            rxNext = rxByte; // R6
        end
        if (accessWr && hitTx) begin
            txNext = pwdata[7:0]; // R7
        end
    end

    // Read data staging and interrupt level
    always_comb begin
        rdataNext = rdataReg;
        staleNext = staleReg;
        if (setupPhase) begin
            staleNext = rxByteValid;
            rdataNext = twr_pkg::RDATA_RST;
            if (!pwrite) begin
                if (hitStatus) begin
                    rdataNext = statReg;
                end else if (hitMask) begin
                    rdataNext = maskReg; // R3
                end else if (hitRx) begin
                    rdataNext = {24'h000000, rxReg}; // R6
                end else if (hitTx) begin
                    rdataNext = {24'h000000, txReg}; // R7
                end
            end
        end
        irqNext = |(statNext & maskNext); // R10
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            maskReg  <= twr_pkg::MASK_RST; // R3
            statReg  <= twr_pkg::STATUS_RST;
            rxReg    <= twr_pkg::BYTE_RST;
            txReg    <= twr_pkg::BYTE_RST;
            rdataReg <= twr_pkg::RDATA_RST;
            staleReg <= 1'b0;
            irqReg   <= 1'b0;
        end else begin
            maskReg  <= maskNext;
            statReg  <= statNext;
            rxReg    <= rxNext;
            txReg    <= txNext;
            rdataReg <= rdataNext;
            staleReg <= staleNext;
            irqReg   <= irqNext;
        end
    end

    assign prdata  = rdataReg;
    assign txByte  = txReg;
    assign txReady = statReg[twr_pkg::BIT_TX_READY];
    assign rxReady = statReg[twr_pkg::BIT_RX_READY];
    assign irq     = irqReg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    chk_mask_set_bits: assert property ( // R1
        accessWr && hitSet && !hitClr |=>
            ((maskReg & $past(pwdata) & twr_pkg::SRC_MASK)
             == ($past(pwdata) & twr_pkg::SRC_MASK)))
        else $error("enable write did not set mask bits");

    chk_mask_clr_bits: assert property ( // R2
        accessWr && hitClr |=>
            ((maskReg & $past(pwdata)) == 32'h00000000))
        else $error("disable write did not clear mask bits");

    chk_mask_holds: assert property ( // R1
        !(accessWr && (hitSet || hitClr)) |=> $stable(maskReg))
        else $error("mask changed without a mask write");

    chk_mask_unused: assert property ( // R4
        (maskReg & ~twr_pkg::SRC_MASK) == 32'h00000000)
        else $error("unused mask bit set");

    chk_mask_after_rst: assert property ( // R3
        $fell(srst) |-> (maskReg == twr_pkg::MASK_RST))
        else $error("mask not zero after reset");

    chk_mask_readback: assert property ( // R3
        setupPhase && !pwrite && hitMask |=>
            (prdata == $past(maskReg)))
        else $error("mask read returned wrong value");

    chk_rx_read_data: assert property ( // R6
        setupPhase && !pwrite && hitRx |=>
            (prdata[31:8] == 24'h000000) && (prdata[7:0] == $past(rxReg)))
        else $error("receive byte read wrong");

    chk_rx_lands: assert property ( // R8
        rxByteValid |=> rxReady && (rxReg == $past(rxByte)))
        else $error("received byte not flagged");

    chk_rx_read_clears: assert property ( // R8
        accessRd && hitRx && !staleReg && !rxByteValid |=> !rxReady)
        else $error("receive ready not cleared by read");

    chk_tx_write_clears: assert property ( // R9
        accessWr && hitTx && !txByteTaken |=>
            !txReady && (txByte == $past(pwdata[7:0])))
        else $error("transmit write not taken");

    chk_tx_taken_sets: assert property ( // R9
        txByteTaken |=> txReady)
        else $error("transmit ready not set after shift");

    chk_tx_write_data: assert property ( // R7
        accessWr && hitTx |=> ##1 (txByte == $past(pwdata[7:0], 2)))
        else $error("transmit byte lost");

    chk_irq_level: assert property ( // R10
        ##1 (irq == |(statReg & maskReg)))
        else $error("interrupt level disagrees with status and mask");

    chk_upper_mask_zero: assert property ( // R5
        accessWr && hitSet |=> (maskReg[31:16] == 16'h0000))
        else $error("upper mask bits set");

    chk_ro_write_flag: assert property ( // R3
        accessWr && (hitMask || hitRx) |-> pslverr)
        else $error("write to read-only word not flagged");

    chk_rx_ro_inert: assert property ( // R6
        accessWr && hitRx && !rxByteValid |=> $stable(rxReg))
        else $error("write changed receive byte");

    chk_rx_stale_keeps: assert property ( // R8
        accessRd && hitRx && staleReg |=> rxReady)
        else $error("late byte lost its ready flag");

    chk_overrun_flag: assert property ( // R4
        rxByteValid && rxReady |=> statReg[twr_pkg::BIT_OVERRUN])
        else $error("overrun not flagged");

    chk_event_sticky: assert property ( // R10
        (eventPulse & twr_pkg::EVT_MASK) != 32'h00000000 |=>
            ((statReg & $past(eventPulse) & twr_pkg::EVT_MASK)
             == ($past(eventPulse) & twr_pkg::EVT_MASK)))
        else $error("event did not set its status bit");

    chk_sticky_holds: assert property ( // R4
        !(accessWr && hitStatus) && !rxByteValid
            && (eventPulse == 32'h00000000) |=>
            (((statReg ^ $past(statReg)) & twr_pkg::EVT_MASK)
             == 32'h00000000))
        else $error("sticky status changed on its own");

    chk_status_clear: assert property ( // R10
        accessWr && hitStatus && !rxByteValid
            && (eventPulse == 32'h00000000) |=>
            ((statReg & $past(pwdata) & twr_pkg::EVT_MASK) == 32'h00000000))
        else $error("status write did not clear");

    chk_tx_byte_holds: assert property ( // R7
        !(accessWr && hitTx) |=> $stable(txByte))
        else $error("transmit byte changed without a write");

    chk_rx_byte_holds: assert property ( // R6
        !rxByteValid |=> $stable(rxReg))
        else $error("receive byte changed without a new byte");

    chk_status_unused: assert property ( // R5
        (statReg & ~twr_pkg::SRC_MASK) == 32'h00000000)
        else $error("unused status bit set");

    chk_irq_all_masked: assert property ( // R10
        (maskReg == 32'h00000000) |-> !irq)
        else $error("interrupt high with every source masked");

    chk_unmapped_flag: assert property (
        psel && penable && !mapped |-> pslverr)
        else $error("unmapped access not flagged");

    chk_unmapped_reads: assert property (
        setupPhase && !pwrite && !mapped |=> (prdata == 32'h00000000))
        else $error("unmapped read returned data");

    chk_tx_ready_rst: assert property ( // R9
        $fell(srst) |-> txReady && (txByte == twr_pkg::BYTE_RST))
        else $error("transmit side not at reset values");

    chk_rx_after_rst: assert property ( // R6
        $fell(srst) |-> !rxReady && (prdata == twr_pkg::RDATA_RST))
        else $error("receive side not at reset values");

endmodule
